// >>> verilog/ipc_top.sv
// ipc_top: pending registers, control/status register and core request path.
// assumes irq sources and stop/wait level are synchronous to CLK_SYS; pin is not.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module ipc_top #(
  parameter logic [6:0] EXT_VEC    = 7'h41,
  parameter logic [1:0] PERIPH_LVL = 2'h2
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic [81:2]          IRQ_REQ,
  input  wire logic                 EXT_IRQ_PIN_N,
  input  wire logic                 STOP_WAIT,
  input  wire logic                 CORE_ACK,
  output ipc_pkg::ipc_core_t        CORE_OUT,
  output logic                      RESET_VECTOR_SEL,
  output logic                      IRQ_OUT
);
  logic [2:0]  pin_sync_q;
  logic [1:0]  rst_done_q;
  logic        global_irq_mask_q;
  logic        ext_irq_edge_select_q;
  logic        edge_latch_q;
  logic [79:0] ven_q;
  logic        irq_q;
  logic [1:0]  lvl_q;
  logic [6:0]  vec_q;
  logic [1:0]  taken_priority_level_q;
  logic [6:0]  taken_vector_number_q;
  logic [1:0]  ev_st_q;
  logic [1:0]  ev_en_q;
  logic [31:0] prdata_q;
  logic        err_q;

  wire         ext_irq_pin_level = pin_sync_q[1];
  wire         fall_seen = pin_sync_q[2] & ~pin_sync_q[1];
  wire         edge_mode = ext_irq_edge_select_q & ~STOP_WAIT;
  wire         ack_ext = CORE_ACK & (vec_q == EXT_VEC);
  wire         ext_req = edge_mode ? edge_latch_q : ~ext_irq_pin_level;
  wire         ext_fall_ev = edge_mode & fall_seen;

  // pending and enabled, one bit per vector
  logic [79:0] pend;
  logic [79:0] act;
  genvar gv;
  generate
    for (gv = 0; gv < ipc_pkg::NVEC; gv++) begin : g_vec
      localparam logic [6:0] VNUM = 7'(gv + ipc_pkg::VEC_LO);
      assign pend[gv] = (VNUM == EXT_VEC) ? ext_req : IRQ_REQ[gv + ipc_pkg::VEC_LO];
      assign act[gv]  = pend[gv] & ven_q[gv];
    end
  endgenerate

  // lowest vector number wins among equals
  logic [6:0] sel_vec;
  always_comb begin
    sel_vec = 7'h00;
    for (int i = ipc_pkg::NVEC - 1; i >= 0; i--) begin
      if (act[i]) begin
        sel_vec = 7'(i + ipc_pkg::VEC_LO);
      end
    end
  end

  // new level presented: PERIPH_LVL for peripheral vectors, core vectors fixed at CORE_LVL
  wire [1:0] sel_lvl = (sel_vec <= 7'(ipc_pkg::CORE_VEC_HI)) ?
                       ipc_pkg::CORE_LVL : PERIPH_LVL;
  wire       out_of_reset = rst_done_q[1];
  wire       irq_d = (|act) & ~global_irq_mask_q & out_of_reset;

  // apb decode
  wire [5:0] idx      = PADDR[7:2];
  wire       aligned  = (PADDR[1:0] == 2'h0);
  wire       is_pend  = (idx >= ipc_pkg::IDX_PEND0) && (idx <= ipc_pkg::IDX_PEND5);
  wire       is_ctrl  = (idx == ipc_pkg::IDX_CTRL);
  wire       is_evst  = (idx == ipc_pkg::IDX_EVST);
  wire       is_evclr = (idx == ipc_pkg::IDX_EVCLR);
  wire       is_even  = (idx == ipc_pkg::IDX_EVEN);
  wire       is_ven   = (idx >= ipc_pkg::IDX_VEN0) && (idx <= ipc_pkg::IDX_VEN2);
  wire       mapped   = aligned & (is_pend | is_ctrl | is_evst | is_evclr | is_even | is_ven);
  wire       setup    = PSEL & ~PENABLE;
  wire       wr       = PSEL & PENABLE & PWRITE & mapped;
  wire [2:0] pend_sel = 3'(idx - ipc_pkg::IDX_PEND0);
  wire [1:0] ven_sel  = 2'(idx - ipc_pkg::IDX_VEN0);

  // active-low pending image, reserved ends read 1
  wire [95:0] pend_img = {ipc_pkg::PEND5_RSVD, ~pend, 1'b1};
  wire [95:0] ven_img  = {16'h0000, ven_q};

  logic [15:0] ctrl_word;
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[ipc_pkg::B_INT] = irq_q;
    ctrl_word[ipc_pkg::B_LVL +: 2] = taken_priority_level_q;
    ctrl_word[ipc_pkg::B_VEC +: 7] = taken_vector_number_q;
    ctrl_word[ipc_pkg::B_DIS] = global_irq_mask_q;
    ctrl_word[ipc_pkg::B_ONE] = 1'b1;
    ctrl_word[ipc_pkg::B_PIN] = ext_irq_pin_level;
    ctrl_word[ipc_pkg::B_EDGE] = ext_irq_edge_select_q;
  end

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_pend) begin
      rd_word = {16'h0000, pend_img[16 * pend_sel +: 16]};
    end else if (is_ctrl) begin
      rd_word = {16'h0000, ctrl_word};
    end else if (is_evst) begin
      rd_word = {30'h0, ev_st_q};
    end else if (is_even) begin
      rd_word = {30'h0, ev_en_q};
    end else if (is_ven) begin
      rd_word = ven_img[32 * ven_sel +: 32];
    end
  end

  // enable words; write lanes beyond vector 81 are dropped
  logic [79:0] ven_d;
  always_comb begin
    logic [95:0] tmp;
    tmp = ven_img;
    if (wr && is_ven) begin
      tmp[32 * ven_sel +: 32] = PWDATA;
    end
    ven_d = tmp[79:0];
  end

  // sticky events: set wins over a same-cycle clear
  wire [1:0] ev_set = {ext_fall_ev, CORE_ACK};
  wire [1:0] ev_clr = (wr && is_evclr) ? PWDATA[1:0] : 2'h0;
  wire [1:0] ev_st_d = (ev_st_q & ~ev_clr) | ev_set;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_sync_q <= 3'h7;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], EXT_IRQ_PIN_N};
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rst_done_q <= 2'h0;
    end else begin
      rst_done_q <= {rst_done_q[0], 1'b1};
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      global_irq_mask_q     <= 1'b0;
      ext_irq_edge_select_q <= 1'b0;
    end else if (wr && is_ctrl) begin
      global_irq_mask_q     <= PWDATA[ipc_pkg::B_DIS];
      ext_irq_edge_select_q <= PWDATA[ipc_pkg::B_EDGE];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      edge_latch_q <= 1'b0;
    end else if (ext_fall_ev) begin
      edge_latch_q <= 1'b1;
    end else if (ack_ext || !edge_mode) begin
      edge_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ven_q <= ipc_pkg::VEN_RESET;
    end else begin
      ven_q <= ven_d;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_q <= 1'b0;
      lvl_q <= 2'h0;
      vec_q <= 7'h00;
    end else begin
      irq_q <= irq_d;
      lvl_q <= sel_lvl;
      vec_q <= sel_vec;
    end
  end

  // nested entry may overwrite before the first routine reads it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      taken_priority_level_q <= 2'h0;
      taken_vector_number_q  <= 7'h00;
    end else if (CORE_ACK) begin
      taken_priority_level_q <= lvl_q;
      taken_vector_number_q  <= vec_q;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ev_st_q <= 2'h0;
      ev_en_q <= 2'h0;
    end else begin
      ev_st_q <= ev_st_d;
      if (wr && is_even) begin
        ev_en_q <= PWDATA[1:0];
      end
    end
  end

  // read data caught in setup so it leaves a flip-flop
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= PWRITE ? 32'h0000_0000 : rd_word;
      err_q    <= ~mapped;
    end
  end

  assign PRDATA           = prdata_q;
  assign PREADY           = PSEL & PENABLE;
  assign PSLVERR          = PSEL & PENABLE & err_q;
  assign CORE_OUT.req     = irq_q;
  assign CORE_OUT.lvl     = lvl_q;
  assign CORE_OUT.vec     = vec_q;
  assign RESET_VECTOR_SEL = ~out_of_reset;
  assign IRQ_OUT          = |(ev_st_q & ev_en_q);

  sequence s_fall;
    edge_mode && fall_seen;
  endsequence

  sequence s_rd_setup(logic hit);
    setup && !PWRITE && hit && aligned;
  endsequence

  property p_reset_vec;
    @(posedge CLK_SYS) disable iff (RST)
    !rst_done_q[1] |-> RESET_VECTOR_SEL && !CORE_OUT.req;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector dropped early");

  property p_mask;
    @(posedge CLK_SYS) disable iff (RST)
    global_irq_mask_q |=> !CORE_OUT.req;
  endproperty
  a_mask: assert property (p_mask) else $error("request while disabled");

  property p_capture;
    @(posedge CLK_SYS) disable iff (RST)
    CORE_ACK |=> taken_vector_number_q == $past(vec_q) &&
                 taken_priority_level_q == $past(lvl_q);
  endproperty
  a_capture: assert property (p_capture) else $error("taken fields not captured");

  property p_hold;
    @(posedge CLK_SYS) disable iff (RST)
    !CORE_ACK |=> $stable(taken_vector_number_q) && $stable(taken_priority_level_q);
  endproperty
  a_hold: assert property (p_hold) else $error("taken fields changed without entry");

  property p_edge_latch;
    @(posedge CLK_SYS) disable iff (RST)
    s_fall ##1 (edge_mode && !ack_ext) [*2] |-> edge_latch_q && ext_req;
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge request lost");

  property p_stop_level;
    @(posedge CLK_SYS) disable iff (RST)
    STOP_WAIT |-> ext_req == !ext_irq_pin_level;
  endproperty
  a_stop_level: assert property (p_stop_level) else $error("pin not level sensed");

  property p_int_bit;
    @(posedge CLK_SYS) disable iff (RST)
    s_rd_setup(is_ctrl) |=> PRDATA[ipc_pkg::B_INT] == $past(irq_q) &&
                            PRDATA[ipc_pkg::B_ONE] && !PRDATA[3] && !PRDATA[1];
  endproperty
  a_int_bit: assert property (p_int_bit) else $error("control read wrong");

  property p_pend5;
    @(posedge CLK_SYS) disable iff (RST)
    s_rd_setup(idx == ipc_pkg::IDX_PEND5) |=>
      PRDATA[15:1] == ipc_pkg::PEND5_RSVD && PRDATA[0] == !$past(pend[79]);
  endproperty
  a_pend5: assert property (p_pend5) else $error("last pending word wrong");

endmodule : ipc_top

// >>> common/ipc_pkg.sv
// ipc_pkg: constants and types of the interrupt pending and control block.
// assumes APB word access; register indices are word numbers (byte = 4 x idx).
// Functional notes
// - Vectors 2..81 pending shown one bit each over six read-only registers.
// - Pending bit reads 0 when a request is pending, 1 when not.
// - Bits above vector 81 in the last pending register read 1, ignore writes.
// - Control bit 15 reads 1 while a request is driven to the core.
// - Bits 14..13 capture the new priority level given when the last irq was taken.
// - Captured level 00,01,10,11 allows nested levels 0-3,1-3,2-3,3 only.
// - Bits 12..6 hold vector number (address bits 7..1) of last taken irq.
// - Captured fields change only on entry to a new service routine.
// - Bit 5 global disable, reset 0, blocks every interrupt when 1.
// - Bit 4 reads 1, bits 3 and 1 read 0, writes have no effect.
// - Bit 2 reads the current level of the external active-low pin.
// - Bit 0, reset 0, picks pin sensing: 0 low level, 1 falling edge.
// - In stop or wait the pin is level sensed whatever bit 0 says.
// - Reset vector driven during reset until second rising edge after release.
// - After reset all registers default; only eight core interrupts enabled.
// - Those eight: illegal instr, stack overflow, misaligned, soft 0-3 and low.
package ipc_pkg;
  localparam int unsigned VEC_LO = 2;
  localparam int unsigned VEC_HI = 81;
  localparam int unsigned NVEC   = 80;
  localparam int unsigned CORE_VEC_HI = 9;
  localparam logic [5:0] IDX_PEND0  = 6'h11;
  localparam logic [5:0] IDX_PEND5  = 6'h16;
  localparam logic [5:0] IDX_CTRL   = 6'h1d;
  localparam logic [5:0] IDX_EVST   = 6'h20;
  localparam logic [5:0] IDX_EVCLR  = 6'h21;
  localparam logic [5:0] IDX_EVEN   = 6'h22;
  localparam logic [5:0] IDX_VEN0   = 6'h23;
  localparam logic [5:0] IDX_VEN2   = 6'h25;
  localparam int unsigned B_INT  = 15;
  localparam int unsigned B_LVL  = 13;
  localparam int unsigned B_VEC  = 6;
  localparam int unsigned B_DIS  = 5;
  localparam int unsigned B_ONE  = 4;
  localparam int unsigned B_PIN  = 2;
  localparam int unsigned B_EDGE = 0;
  localparam logic [14:0] PEND5_RSVD = 15'h7fff;
  localparam logic [79:0] VEN_RESET  = 80'hff;
  localparam logic [1:0]  CORE_LVL   = 2'h3;
  localparam int unsigned NEV = 2;
  typedef struct packed {
    logic       req;
    logic [1:0] lvl;
    logic [6:0] vec;
  } ipc_core_t;
endpackage : ipc_pkg

// >>> tb/ipc_core_model.sv
// ipc_core_model: processor core stand-in that takes one request per command.
// assumes CORE_OUT is registered and CORE_ACK is sampled at CLK_SYS rising edges.
`timescale 1ns/10ps
module ipc_core_model #(
  parameter int DLY = 3
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire ipc_pkg::ipc_core_t core_in,
  input  wire logic               go,
  output logic                    ack
);
  logic       armed_q;
  logic [3:0] cnt_q;
  // acks only when told: level sources stay high and would loop forever
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
      cnt_q   <= 4'h0;
      ack     <= 1'b0;
    end else begin
      ack <= 1'b0;
      if (go) begin
        armed_q <= 1'b1;
        cnt_q   <= 4'h0;
      end else if (armed_q && core_in.req) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'(DLY)) begin
          ack     <= 1'b1;
          armed_q <= 1'b0;
        end
      end
    end
  end
endmodule : ipc_core_model

// >>> tb/tb.sv
// tb: scenario tasks for the pending, control and core request paths.
// assumes an APB slave that answers by pready and a registered CORE_OUT.
`timescale 1ns/10ps
module tb;
  logic               clk, rst, psel, penable, pwrite, pready, pslverr;
  logic               pin_n, stop_wait, ack, go, rvs, irq_out, rerr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rdat;
  logic [81:2]        irq_req;
  ipc_pkg::ipc_core_t core;
  int                 error_cnt, samples_checked;
  localparam logic [7:0] A_CTRL = {ipc_pkg::IDX_CTRL, 2'b00};
  localparam logic [7:0] A_P0   = {ipc_pkg::IDX_PEND0, 2'b00};
  localparam logic [7:0] A_P5   = {ipc_pkg::IDX_PEND5, 2'b00};
  localparam logic [7:0] A_EVST = {ipc_pkg::IDX_EVST, 2'b00};
  localparam logic [7:0] A_EVCL = {ipc_pkg::IDX_EVCLR, 2'b00};
  localparam logic [7:0] A_EVEN = {ipc_pkg::IDX_EVEN, 2'b00};
  localparam logic [7:0] A_VEN0 = {ipc_pkg::IDX_VEN0, 2'b00};
  ipc_top #(.EXT_VEC(7'h09)) u_dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ_REQ(irq_req), .EXT_IRQ_PIN_N(pin_n),
    .STOP_WAIT(stop_wait), .CORE_ACK(ack), .CORE_OUT(core), .RESET_VECTOR_SEL(rvs),
    .IRQ_OUT(irq_out));
  ipc_core_model u_core (.clk(clk), .rst(rst), .core_in(core), .go(go), .ack(ack));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // entered right after a rising edge; holds the request until pready is seen
  // one idle edge after release, so no strobe is driven twice in a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic take;
    int n;
    n = 0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (ack !== 1'b1 && n < 30) begin
      n++;
      @(negedge clk);
    end
    chk({31'h0, ack}, 32'h1);
    cyc(2);
  endtask : take
  task automatic t_regs;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat, 32'h14);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, A_P0 + 8'(4 * i), 32'h0);
      chk(rdat, 32'hffff);
    end
    apb(1'b1, A_P5, 32'h0);
    apb(1'b0, A_P5, 32'h0);
    chk(rdat, 32'hffff);
    apb(1'b0, 8'h40, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
  endtask : t_regs
  task automatic t_pend;
    irq_req[81] <= 1'b1;
    irq_req[10] <= 1'b1;
    cyc(3);
    apb(1'b0, A_P5, 32'h0);
    chk(rdat, 32'hfffe);
    apb(1'b0, A_P0, 32'h0);
    chk(rdat, 32'hfdff);
    chk({31'h0, core.req}, 32'h0);
    irq_req <= '0;
    cyc(3);
  endtask : t_pend
  task automatic t_core;
    apb(1'b1, A_EVEN, 32'h1);
    irq_req[5] <= 1'b1;
    cyc(3);
    chk({core.req, core.lvl, core.vec}, {22'h0, 1'b1, 2'h3, 7'h05});
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat & 32'h8000, 32'h8000);
    take();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat & 32'h7fc0, 32'h6140);
    chk({31'h0, irq_out}, 32'h1);
    irq_req[4] <= 1'b1;
    cyc(3);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat & 32'h1fc0, 32'h0140);
    take();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat & 32'h1fc0, 32'h0100);
    apb(1'b1, A_CTRL, 32'h2a);
    cyc(3);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat & 32'h803e, 32'h34);
    chk({31'h0, core.req}, 32'h0);
    apb(1'b0, A_P0, 32'h0);
    chk(rdat, 32'hffe7);
    apb(1'b0, A_EVST, 32'h0);
    chk(rdat & 32'h1, 32'h1);
    apb(1'b1, A_EVEN, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, A_EVCL, 32'h1);
    apb(1'b1, A_EVEN, 32'h1);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, A_EVEN, 32'h0);
    apb(1'b1, A_CTRL, 32'h0);
    irq_req <= '0;
    cyc(3);
  endtask : t_core
  // peripheral vector opened by software, presented at the peripheral level
  task automatic t_lvl;
    apb(1'b1, A_VEN0, 32'h0004_00ff);
    irq_req[20] <= 1'b1;
    cyc(3);
    chk({core.req, core.lvl, core.vec}, {22'h0, 1'b1, 2'h2, 7'h14});
    take();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat & 32'h7fc0, 32'h4500);
    apb(1'b0, A_VEN0, 32'h0);
    chk(rdat, 32'h0004_00ff);
    irq_req <= '0;
    apb(1'b1, A_VEN0, 32'h0000_00ff);
  endtask : t_lvl
  task automatic pin_step(input logic lvl, input logic [31:0] exp);
    pin_n <= lvl;
    cyc(6);
    apb(1'b0, A_P0, 32'h0);
    chk(rdat, exp);
  endtask : pin_step
  task automatic t_pin;
    pin_step(1'b0, 32'hfeff);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rdat & 32'h4, 32'h0);
    pin_step(1'b1, 32'hffff);
    apb(1'b1, A_CTRL, 32'h1);
    pin_step(1'b0, 32'hfeff);
    pin_step(1'b1, 32'hfeff);
    take();
    apb(1'b0, A_P0, 32'h0);
    chk(rdat, 32'hffff);
    stop_wait <= 1'b1;
    pin_step(1'b0, 32'hfeff);
    pin_step(1'b1, 32'hffff);
  endtask : t_pin
  initial begin
    {psel, penable, pwrite, go, stop_wait, rst} = 6'h01;
    {paddr, pwdata, irq_req} = '0;
    pin_n = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    cyc(20);
    chk({31'h0, rvs}, 32'h1);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({31'h0, rvs}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, rvs}, 32'h0);
    @(posedge clk);
    t_regs();
    t_pend();
    t_core();
    t_lvl();
    t_pin();
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule : tb
